// File: spac_top.sv
// Cell polarity, aux reference select and aux settling sequencing.
// Assumes an APB master, an external scan sequencer and ADC/comparator datapaths.
module spac_top
(
    input wire logic clk_in, // System clock 10 MHz
    input wire logic rst_n_in, // Async reset, active low
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB write
    input wire logic [31:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error on unmapped address
    output logic irq_out, // Level interrupt
    input wire logic scan_req_in, // Scan request pulse
    input wire logic scan_done_in, // Scan finished pulse
    input wire logic other_meas_active_in, // Other measurement in progress
    input wire logic auto_mode_in, // Thermistor auto mode
    input wire logic balance_diag_scan_in, // Balance-switch diagnostic scan
    input wire logic [spac_pkg::NCELL-1:0] cell_fault_in, // Raw per-cell faults
    input wire logic [spac_pkg::NAUX-1:0] aux_pin_io_mode_enable_in, // Aux pin IO mode
    input wire logic two_wire_master_enable_in, // Two-wire master on aux 1:0
    input wire logic [spac_pkg::NAUX-1:0] aux_measure_enable_in, // Aux measure enables
    input wire logic [spac_pkg::NAUX-1:0] aux_analog_cfg_in, // Aux configured analog
    input wire logic [spac_pkg::NAUX-1:0] aux_result_valid_in, // New aux result
    input wire logic [13:0] aux_result_in [spac_pkg::NAUX], // Aux raw results
    output logic [spac_pkg::NCELL-1:0] stats_include_out, // Cells in min/max/mismatch
    output logic [spac_pkg::NCELL-1:0] cell_fault_out, // Faults after masking
    output logic [spac_pkg::NCELL-1:0] bipolar_thresh_sel_out, // Use bipolar thresholds
    output logic [spac_pkg::NCELL-1:0] comp_scan_include_out, // Cells in comparator scan
    output logic [spac_pkg::NAUX-1:0] aux_abs_ref_out, // Effective absolute reference
    output logic [spac_pkg::NAUX-1:0] aux_abs_thresh_out, // Absolute threshold set
    output logic [spac_pkg::NAUX-1:0] aux_settle_apply_out, // Aux under settling
    output logic settle_done_out, // Settling expired pulse
    output logic high_voltage_pump_out, // Pump refresh request
    output logic thermistor_bias_output_out, // Thermistor bias drive
    output logic [13:0] aux_result_out [spac_pkg::NAUX] // Aux results as read back
);
    logic [15:0] pol_reg, next_pol_reg;
    logic [15:0] auxref_reg, next_auxref_reg;
    logic [15:0] aux_settle_count_reg, next_aux_settle_count_reg;
    logic [spac_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [spac_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] widx;
    logic acc_wr, acc_rd, setup;

    spac_pkg::spac_state_t state, next_state;
    logic [spac_pkg::SETTLE_W-1:0] settle_cnt, next_settle_cnt;
    logic [spac_pkg::TICK_W-1:0] tick_cnt, next_tick_cnt;
    logic settle_done_ev, pump_start_ev;
    logic next_pump, next_bias;
    logic [spac_pkg::NAUX-1:0] ref_ignore, next_abs_ref, next_settle_apply;
    logic [spac_pkg::NCELL-1:0] bip, next_stats, next_fault, next_comp;
    logic [13:0] next_result [spac_pkg::NAUX];

    assign widx = paddr_in[9:2];
    assign setup = psel_in && !penable_in;
    // Refused transfers flag an error in the access phase and must not commit
    assign acc_wr = psel_in && penable_in && pready_out && !pslverr_out && pwrite_in;
    assign acc_rd = setup && !pwrite_in;
    assign bip = pol_reg[spac_pkg::NCELL-1:0];

    // No wait states: ready rises in the first access cycle, data is latched in setup
    always_comb
    begin
        next_pol_reg = pol_reg;
        next_auxref_reg = auxref_reg;
        next_aux_settle_count_reg = aux_settle_count_reg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_prdata = prdata_out;
        next_pready = setup;
        next_pslverr = 1'b0;
        if (acc_wr)
        begin
            if (widx == spac_pkg::POL_IDX)
                next_pol_reg = pwdata_in[15:0] & spac_pkg::POL_WMASK;
            else if (widx == spac_pkg::AUXREF_IDX)
                next_auxref_reg = pwdata_in[15:0] & spac_pkg::AUXREF_WMASK;
            else if (widx == spac_pkg::AUX_SETTLE_COUNT_IDX)
                next_aux_settle_count_reg = pwdata_in[15:0] & spac_pkg::AUX_SETTLE_COUNT_WMASK;
            else if (widx == spac_pkg::IRQ_MASK_IDX)
                next_irq_mask = pwdata_in[spac_pkg::IRQ_W-1:0];
        end
        if (setup)
        begin
            next_prdata = 32'h0000_0000;
            if (paddr_in[31:10] != 22'h00_0000 || paddr_in[1:0] != 2'b00)
                next_pslverr = 1'b1;
            else if (widx == spac_pkg::POL_IDX)
                next_prdata = {16'h0000, pol_reg};
            else if (widx == spac_pkg::AUXREF_IDX)
                next_prdata = {16'h0000, auxref_reg};
            else if (widx == spac_pkg::AUX_SETTLE_COUNT_IDX)
                next_prdata = {16'h0000, aux_settle_count_reg};
            else if (widx == spac_pkg::IRQ_STAT_IDX)
                next_prdata = {30'h0000_0000, irq_stat};
            else if (widx == spac_pkg::IRQ_MASK_IDX)
                next_prdata = {30'h0000_0000, irq_mask};
            else
                next_pslverr = 1'b1;
        end
        // Read clears status; a new event in the same cycle still wins
        if (acc_rd && !next_pslverr && widx == spac_pkg::IRQ_STAT_IDX)
            next_irq_stat = '0;
        if (settle_done_ev)
            next_irq_stat[spac_pkg::IRQ_SETTLE_DONE] = 1'b1;
        if (pump_start_ev)
            next_irq_stat[spac_pkg::IRQ_PUMP_START] = 1'b1;
    end

    // Settling sequencer
    always_comb
    begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_tick_cnt = tick_cnt;
        settle_done_ev = 1'b0;
        next_bias = thermistor_bias_output_out;
        case (state)
            spac_pkg::SPAC_IDLE:
            begin
                next_bias = !auto_mode_in;
                if (scan_req_in)
                begin
                    next_settle_cnt = aux_settle_count_reg[spac_pkg::SETTLE_W-1:0];
                    next_tick_cnt = '0;
                    next_bias = 1'b1;
                    next_state = spac_pkg::SPAC_SETTLE;
                end
            end
            spac_pkg::SPAC_SETTLE:
            begin
                if (settle_cnt == '0)
                begin
                    settle_done_ev = 1'b1;
                    next_state = spac_pkg::SPAC_MEASURE;
                end
                else if (tick_cnt == spac_pkg::TICK_W'(spac_pkg::TICK_CYC - 1))
                begin
                    next_tick_cnt = '0;
                    next_settle_cnt = settle_cnt - 1'b1;
                end
                else
                    next_tick_cnt = tick_cnt + 1'b1;
            end
            spac_pkg::SPAC_MEASURE:
            begin
                if (scan_done_in)
                    next_state = spac_pkg::SPAC_IDLE;
            end
            default: next_state = spac_pkg::SPAC_IDLE;
        endcase
        // A zero count means the delay has already expired: no refresh then
        next_pump = (next_state == spac_pkg::SPAC_SETTLE) && (next_settle_cnt != '0)
            && !other_meas_active_in;
        pump_start_ev = next_pump && !high_voltage_pump_out;
    end

    // Per-channel steering
    always_comb
    begin
        ref_ignore = aux_pin_io_mode_enable_in;
        if (two_wire_master_enable_in)
            ref_ignore[spac_pkg::NTWI-1:0] = {spac_pkg::NTWI{1'b1}};
        next_abs_ref = auxref_reg[spac_pkg::NAUX-1:0] & ~ref_ignore;
        next_settle_apply = (state == spac_pkg::SPAC_SETTLE) ? aux_measure_enable_in : '0;
        next_stats = pol_reg[spac_pkg::STATS_POL_BIT] ? bip : ~bip;
        next_fault = balance_diag_scan_in ? (cell_fault_in & ~bip) : cell_fault_in;
        next_comp = ~bip;
        for (int i = 0; i < spac_pkg::NAUX; i++)
        begin
            if (!aux_analog_cfg_in[i])
                next_result[i] = 14'h0000;
            else if (aux_result_valid_in[i] && aux_measure_enable_in[i])
                next_result[i] = aux_result_in[i];
            else
                next_result[i] = aux_result_out[i];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pol_reg <= spac_pkg::POL_RESET;
            auxref_reg <= spac_pkg::AUXREF_RESET;
            aux_settle_count_reg <= spac_pkg::AUX_SETTLE_COUNT_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            state <= spac_pkg::SPAC_IDLE;
            settle_cnt <= '0;
            tick_cnt <= '0;
            settle_done_out <= 1'b0;
            high_voltage_pump_out <= 1'b0;
            thermistor_bias_output_out <= 1'b0;
            stats_include_out <= '0;
            cell_fault_out <= '0;
            bipolar_thresh_sel_out <= '0;
            comp_scan_include_out <= '0;
            aux_abs_ref_out <= '0;
            aux_abs_thresh_out <= '0;
            aux_settle_apply_out <= '0;
            for (int i = 0; i < spac_pkg::NAUX; i++)
                aux_result_out[i] <= 14'h0000;
        end
        else
        begin
            pol_reg <= next_pol_reg;
            auxref_reg <= next_auxref_reg;
            aux_settle_count_reg <= next_aux_settle_count_reg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata_out <= next_prdata;
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
            irq_out <= |(next_irq_stat & next_irq_mask);
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            tick_cnt <= next_tick_cnt;
            settle_done_out <= settle_done_ev;
            high_voltage_pump_out <= next_pump;
            thermistor_bias_output_out <= next_bias;
            stats_include_out <= next_stats;
            cell_fault_out <= next_fault;
            bipolar_thresh_sel_out <= bip;
            comp_scan_include_out <= next_comp;
            aux_abs_ref_out <= next_abs_ref;
            aux_abs_thresh_out <= next_abs_ref;
            aux_settle_apply_out <= next_settle_apply;
            aux_result_out <= next_result;
        end
    end

    sequence settle_start_s;
        state == spac_pkg::SPAC_IDLE && scan_req_in;
    endsequence
    sequence zero_settle_s;
        settle_cnt == '0 && state == spac_pkg::SPAC_SETTLE;
    endsequence

    stats_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> stats_include_out == ($past(pol_reg[15]) ? $past(bip) : ~$past(bip)))
        else $error("stats include set wrong");
    pol_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pol_reg[14] == 1'b0)
        else $error("reserved polarity bit set");
    diag_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        balance_diag_scan_in |=> (cell_fault_out & $past(bip)) == '0)
        else $error("bipolar fault not masked");
    bip_thresh_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> bipolar_thresh_sel_out == $past(bip))
        else $error("threshold select wrong");
    comp_skip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> (comp_scan_include_out & $past(bip)) == '0)
        else $error("bipolar cell in comparator scan");
    twi_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        two_wire_master_enable_in |=> aux_abs_ref_out[1:0] == 2'b00)
        else $error("two-wire ref not ignored");
    io_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> (aux_abs_ref_out & $past(aux_pin_io_mode_enable_in)) == '0)
        else $error("io mode ref not ignored");
    settle_begin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        settle_start_s |=> state == spac_pkg::SPAC_SETTLE && thermistor_bias_output_out)
        else $error("settling not started");
    zero_expire_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        zero_settle_s |=> settle_done_out && state == spac_pkg::SPAC_MEASURE)
        else $error("expiry not signalled");
    tick_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == spac_pkg::SPAC_SETTLE && settle_cnt != '0 && tick_cnt == '0
        |-> ##60 settle_cnt == $past(settle_cnt, 60) - 1'b1)
        else $error("tick not 6 us");
    pump_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        high_voltage_pump_out |-> state == spac_pkg::SPAC_SETTLE && settle_cnt != '0)
        else $error("pump outside settling");
    unconfig_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !aux_analog_cfg_in[0] |=> aux_result_out[0] == 14'h0000)
        else $error("unconfigured aux not zero");
endmodule

// File: spac_pkg.sv
// Package for the scan polarity and aux reference configuration block.
// Assumes a 10 MHz system clock and an APB register port with 32-bit data.
package spac_pkg;
    // Printed offsets are not multiples of four: these are word indexes
    localparam logic [7:0] POL_IDX = 8'h5f;
    localparam logic [7:0] AUXREF_IDX = 8'h60;
    localparam logic [7:0] AUX_SETTLE_COUNT_IDX = 8'h61;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h70;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h71;
    localparam int NCELL = 14;
    localparam int NAUX = 6;
    localparam int NTWI = 2;
    localparam int STATS_POL_BIT = 15;
    localparam int SETTLE_W = 10;
    localparam logic [15:0] POL_RESET = 16'h0000;
    localparam logic [15:0] AUXREF_RESET = 16'h0000;
    localparam logic [15:0] AUX_SETTLE_COUNT_RESET = 16'h0000;
    localparam logic [15:0] POL_WMASK = 16'hbfff;
    localparam logic [15:0] AUXREF_WMASK = 16'h003f;
    localparam logic [15:0] AUX_SETTLE_COUNT_WMASK = 16'h03ff;
    // Settling tick of 6 us at 10 MHz
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 6;
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
    localparam int TICK_W = 7;
    // Interrupt status bits
    localparam int IRQ_SETTLE_DONE = 0;
    localparam int IRQ_PUMP_START = 1;
    localparam int IRQ_W = 2;
    typedef enum logic [1:0] {SPAC_IDLE, SPAC_SETTLE, SPAC_MEASURE} spac_state_t;
endpackage

// File: scan_polarity_aux_reference_config_bench.sv
// Self-checking bench for the polarity, aux reference and settling block.
// Assumes spac_pkg and spac_top are compiled first; drives APB and scan ports directly.
module scan_polarity_aux_reference_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, irq;
    logic scan_req = 1'b0, scan_done = 1'b0, other_meas = 1'b0, auto_mode = 1'b1, diag = 1'b0, twi_en = 1'b0;
    logic [13:0] fault = 14'h0000;
    logic [5:0] io_mode = 6'h00, meas_en = 6'h00, analog_cfg = 6'h00, res_valid = 6'h00;
    logic [13:0] aux_res [spac_pkg::NAUX];
    logic [13:0] aux_rd [spac_pkg::NAUX];
    logic [13:0] stats_inc, fault_o, bip_sel, comp_inc;
    logic [5:0] abs_ref, abs_th, settle_apply;
    logic settle_done, pump, bias;
    int num_errors = 0;
    int checks_done = 0;
    always #50 clk_in = ~clk_in;
    spac_top u_spac_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq), .scan_req_in(scan_req), .scan_done_in(scan_done),
        .other_meas_active_in(other_meas), .auto_mode_in(auto_mode), .balance_diag_scan_in(diag),
        .cell_fault_in(fault), .aux_pin_io_mode_enable_in(io_mode), .two_wire_master_enable_in(twi_en),
        .aux_measure_enable_in(meas_en), .aux_analog_cfg_in(analog_cfg), .aux_result_valid_in(res_valid),
        .aux_result_in(aux_res), .stats_include_out(stats_inc), .cell_fault_out(fault_o),
        .bipolar_thresh_sel_out(bip_sel), .comp_scan_include_out(comp_inc), .aux_abs_ref_out(abs_ref),
        .aux_abs_thresh_out(abs_th), .aux_settle_apply_out(settle_apply), .settle_done_out(settle_done),
        .high_voltage_pump_out(pump), .thermistor_bias_output_out(bias), .aux_result_out(aux_rd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready with a bound, never assumes a latency
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h00_0000, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk(32'h0000_0001, 32'h0000_0000);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
    endtask
    task automatic t_reset_values;
        rd_chk(spac_pkg::POL_IDX, 32'h0000_0000);
        rd_chk(spac_pkg::AUXREF_IDX, 32'h0000_0000);
        rd_chk(spac_pkg::AUX_SETTLE_COUNT_IDX, 32'h0000_0000);
        @(negedge clk_in);
        chk({18'h0, stats_inc}, 32'h0000_3fff);
        chk({18'h0, comp_inc}, 32'h0000_3fff);
        @(posedge clk_in);
        auto_mode <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk({31'h0, bias}, 32'h0000_0001);
        @(posedge clk_in);
        auto_mode <= 1'b1;
    endtask
    task automatic t_polarity;
        wr(spac_pkg::POL_IDX, 32'hffff_c005);
        rd_chk(spac_pkg::POL_IDX, 32'h0000_8005);
        fault <= 14'h3fff;
        diag <= 1'b1;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({18'h0, stats_inc}, 32'h0000_0005);
        chk({18'h0, bip_sel}, 32'h0000_0005);
        chk({18'h0, comp_inc}, 32'h0000_3ffa);
        chk({18'h0, fault_o}, 32'h0000_3ffa);
        wr(spac_pkg::POL_IDX, 32'h0000_2001);
        diag <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({18'h0, stats_inc}, 32'h0000_1ffe);
        chk({18'h0, fault_o}, 32'h0000_3fff);
    endtask
    task automatic t_aux_ref;
        wr(spac_pkg::AUXREF_IDX, 32'hffff_ffff);
        io_mode <= 6'h04;
        twi_en <= 1'b1;
        rd_chk(spac_pkg::AUXREF_IDX, 32'h0000_003f);
        @(negedge clk_in);
        chk({26'h0, abs_ref}, 32'h0000_0038);
        chk({26'h0, abs_th}, 32'h0000_0038);
        @(posedge clk_in);
        io_mode <= 6'h00;
        twi_en <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({26'h0, abs_ref}, 32'h0000_003f);
    endtask
    // Scan with a given settle count; cycle count tolerance of one for edge bookkeeping
    task automatic t_scan(input int count);
        int n;
        int exp;
        exp = count * spac_pkg::TICK_CYC + 2;
        wr(spac_pkg::AUX_SETTLE_COUNT_IDX, 32'hffff_fc00 | count);
        rd_chk(spac_pkg::AUX_SETTLE_COUNT_IDX, count);
        wr(spac_pkg::IRQ_MASK_IDX, 32'h0000_0001);
        meas_en <= 6'h2d;
        @(negedge clk_in);
        chk({31'h0, bias}, 32'h0000_0000);
        @(posedge clk_in);
        scan_req <= 1'b1;
        @(posedge clk_in);
        scan_req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
            if (n == 3 && count > 0)
            begin
                chk({31'h0, pump}, 32'h0000_0001);
                chk({26'h0, settle_apply}, 32'h0000_002d);
                chk({31'h0, bias}, 32'h0000_0001);
                other_meas <= 1'b1;
            end
            if (n == 6 && count > 0)
            begin
                chk({31'h0, pump}, 32'h0000_0000);
                other_meas <= 1'b0;
            end
        end
        while (settle_done !== 1'b1 && n < 2000);
        chk((n - 1 >= exp - 1 && n - 1 <= exp + 1), 32'h0000_0001);
        @(posedge clk_in);
        chk({31'h0, settle_done}, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(spac_pkg::IRQ_STAT_IDX, {30'h0, 1'b1, 1'b1} & (count > 0 ? 32'h3 : 32'h1));
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk({31'h0, irq}, 32'h0000_0000);
        @(posedge clk_in);
        scan_done <= 1'b1;
        @(posedge clk_in);
        scan_done <= 1'b0;
        wr(spac_pkg::IRQ_MASK_IDX, 32'h0000_0000);
    endtask
    task automatic t_aux_results;
        analog_cfg <= 6'h03;
        meas_en <= 6'h03;
        aux_res[0] <= 14'h1a5c;
        aux_res[1] <= 14'h2c3a;
        res_valid <= 6'h03;
        @(posedge clk_in);
        res_valid <= 6'h00;
        aux_res[0] <= 14'h0001;
        meas_en <= 6'h02;
        repeat (3) @(posedge clk_in);
        res_valid <= 6'h01;
        @(posedge clk_in);
        res_valid <= 6'h00;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({18'h0, aux_rd[0]}, 32'h0000_1a5c);
        chk({18'h0, aux_rd[1]}, 32'h0000_2c3a);
        @(posedge clk_in);
        analog_cfg <= 6'h01;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk({18'h0, aux_rd[1]}, 32'h0000_0000);
    endtask
    task automatic t_unmapped;
        logic [31:0] rd;
        logic err;
        apb(1'b1, 8'h62, 32'h0000_ffff, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 8'h62, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < spac_pkg::NAUX; i++)
            aux_res[i] = 14'h0000;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset_values();
        t_polarity();
        t_aux_ref();
        t_scan(2);
        t_scan(0);
        t_aux_results();
        t_unmapped();
        end_of_test();
    end
    // Whole run is a few hundred cycles; this bound only catches a hang
    initial
    begin
        #(50_000 * 100);
        num_errors++;
        end_of_test();
    end
endmodule
